// ==== pkg/reint_slice_pkg.sv ====
// Purpose: shared constants, types and decode functions for the vector reinterpret / slice datapath
// Assumes: 16-bit elements, four lanes, 32-bit APB register access
// Notes:   offsets are byte addresses, one aligned word per register

package reint_slice_pkg;

   // ==========================================================================
   // Datapath shape
   localparam int ELEM_W                   = 16;   // Bits per vector element
   localparam int samples_per_period_count = 4;    // Lanes handled per sample period
   localparam int POINT_W                  = 5;    // Holds 0 .. ELEM_W inclusive
   localparam int ADDR_W                   = 12;
   localparam int DATA_W                   = 32;

   // ==========================================================================
   // Default input type and slice configuration
   localparam bit IN_SIGNED_DEF      = 1'b1;
   localparam int IN_POINT_DEF       = 2;
   localparam int SLICE_WIDTH_DEF    = 8;
   localparam int TOP_OFFSET_DEF     = 0;
   localparam int BOTTOM_OFFSET_DEF  = 0;

   // ==========================================================================
   // Register offsets
   localparam logic [ADDR_W-1:0] CTRL_OFF   = 12'h000;
   localparam logic [ADDR_W-1:0] POINT_OFF  = 12'h004;
   localparam logic [ADDR_W-1:0] STATUS_OFF = 12'h008;
   localparam logic [ADDR_W-1:0] SLICE_OFF  = 12'h00c;

   // Control fields
   localparam int CTRL_FORCE_TYPE_BIT  = 0;
   localparam int CTRL_OUT_SIGNED_BIT  = 1;
   localparam int CTRL_FORCE_POINT_BIT = 2;
   localparam int CTRL_BOOL_OUT_BIT    = 3;
   localparam int CTRL_W               = 4;
   localparam logic [CTRL_W-1:0]  CTRL_RST  = 4'h0;
   localparam logic [POINT_W-1:0] POINT_RST = 5'h00;

   // Status fields
   localparam int ST_SIGNED_BIT    = 0;
   localparam int ST_POINT_LSB     = 8;
   localparam int ST_BAD_POINT_BIT = 16;

   // Slice description fields
   localparam int SL_LO_LSB   = 0;
   localparam int SL_HI_LSB   = 8;
   localparam int SL_W_LSB    = 16;
   localparam int SL_BOOL_BIT = 24;

   // Slice output type, always unsigned with point at zero
   localparam logic               SLICE_SIGNED = 1'b0;
   localparam logic [POINT_W-1:0] SLICE_POINT  = 5'h00;

   // ==========================================================================
   // Slice range description
   typedef enum {range_two_bits, range_upper_width, range_lower_width} range_mode_type;
   typedef enum {top_bit_reference, lsb_reference, point_reference}    bit_ref_type;

   // Absolute bit index of an end-point given its reference
   function automatic int bit_position(bit_ref_type ref_sel, int offset, int in_point);
      int pos;
      pos = offset;
      case (ref_sel)
         top_bit_reference : pos = ELEM_W - 1 - offset;
         lsb_reference     : pos = offset;
         point_reference   : pos = in_point + offset;
         default           : pos = offset;
      endcase
      return pos;
   endfunction

   // Low index of the slice from the chosen range form
   function automatic int slice_low(range_mode_type mode, int top_pos, int bot_pos, int width);
      int lo;
      lo = bot_pos;
      case (mode)
         range_upper_width : lo = top_pos - width + 1;
         range_lower_width : lo = bot_pos;
         range_two_bits    : lo = bot_pos;
         default           : lo = bot_pos;
      endcase
      return lo;
   endfunction

endpackage

// ==== logic/reint_lane.sv ====
// Purpose: one lane of the reinterpret function
// Assumes: type labels travel beside the data, outside this lane
// Notes:   pure wiring, no gates and no storage

`timescale 1ns/100ps

module reint_lane
   import reint_slice_pkg::*;
(
   // Element in
   input  wire logic [ELEM_W-1:0] lane_in,
   // Element out
   output logic      [ELEM_W-1:0] lane_out
);

   // ==========================================================================
   // Pass-through
   // Same width, same bit positions; only the label changes elsewhere
   assign lane_out = lane_in;

endmodule

// ==== logic/slice_lane.sv ====
// Purpose: one lane of the slice function
// Assumes: SLICE_LO and SLICE_W place the range wholly inside the element
// Notes:   pure wiring; the range is fixed at elaboration

`timescale 1ns/100ps

module slice_lane
   import reint_slice_pkg::*;
#(
   parameter int SLICE_LO = 0,
   parameter int SLICE_W  = SLICE_WIDTH_DEF
)
(
   // Element in
   input  wire logic [ELEM_W-1:0]  lane_in,
   // Extracted bits out
   output logic      [SLICE_W-1:0] lane_out
);

   // ==========================================================================
   // Contiguous extraction
   // A fixed part-select costs no logic, only routing
   assign lane_out = lane_in[SLICE_LO +: SLICE_W];

endmodule

// ==== logic/vector_reint_slice.sv ====
// Purpose: vector reinterpret and slice datapath with APB type/option registers
// Assumes: input element type known at elaboration; APB master per APB protocol
// Notes:   data paths are wiring only; registers hold type labels and options
//
// The APB interface to the registers and the register offsets were decided locally.

`timescale 1ns/100ps

module vector_reint_slice
   import reint_slice_pkg::*;
#(
   parameter bit             IN_SIGNED     = IN_SIGNED_DEF,
   parameter int             IN_POINT      = IN_POINT_DEF,
   parameter int             SLICE_W       = SLICE_WIDTH_DEF,
   parameter range_mode_type RANGE_MODE    = range_lower_width,
   parameter bit_ref_type    TOP_REF       = top_bit_reference,
   parameter int             TOP_OFFSET    = TOP_OFFSET_DEF,
   parameter bit_ref_type    BOTTOM_REF    = lsb_reference,
   parameter int             BOTTOM_OFFSET = BOTTOM_OFFSET_DEF
)
(
   // Clock and reset
   input  wire logic                                        clk,
   input  wire logic                                        resetn,
   // APB slave
   input  wire logic [ADDR_W-1:0]                           paddr,
   input  wire logic                                        psel,
   input  wire logic                                        penable,
   input  wire logic                                        pwrite,
   input  wire logic [DATA_W-1:0]                           pwdata,
   input  wire logic [3:0]                                  pstrb,
   output logic      [DATA_W-1:0]                           prdata,
   output logic                                             pready,
   output logic                                             pslverr,
   // Vector in
   input  wire logic [samples_per_period_count*ELEM_W-1:0]  vec_in,
   // Reinterpret out
   output logic      [samples_per_period_count*ELEM_W-1:0]  reint_out,
   output logic                                             reint_signed,
   output logic      [POINT_W-1:0]                          reint_point,
   // Slice out
   output logic      [samples_per_period_count*SLICE_W-1:0] slice_out,
   output logic                                             slice_signed,
   output logic      [POINT_W-1:0]                          slice_point,
   output logic                                             slice_is_bool
);

   // ==========================================================================
   // Slice geometry, resolved at elaboration
   // Ends are found from their own reference, then one range form is chosen
   localparam int TOP_POS  = bit_position(TOP_REF, TOP_OFFSET, IN_POINT);
   localparam int BOT_POS  = bit_position(BOTTOM_REF, BOTTOM_OFFSET, IN_POINT);
   localparam int SLICE_LO = slice_low(RANGE_MODE, TOP_POS, BOT_POS, SLICE_W);
   localparam int SLICE_HI = SLICE_LO + SLICE_W - 1;

   // Constant views for the read-only slice register
   localparam logic [7:0] SLICE_LO_V = 8'(SLICE_LO);
   localparam logic [7:0] SLICE_HI_V = 8'(SLICE_HI);
   localparam logic [7:0] SLICE_W_V  = 8'(SLICE_W);
   localparam logic       ONE_BIT    = (SLICE_W == 1);
   localparam logic [POINT_W-1:0] IN_POINT_V = POINT_W'(IN_POINT);
   localparam logic [DATA_W-1:0]  ELEM_W_V   = DATA_W'(ELEM_W);

   // ==========================================================================
   // Register state
   logic [CTRL_W-1:0]  ctrl_q,     ctrl_d;
   logic [POINT_W-1:0] point_q,    point_d;
   logic               bad_pt_q,   bad_pt_d;
   logic [DATA_W-1:0]  rdata_q,    rdata_d;

   // Bus decode terms
   logic               setup_ph;
   logic               access_ph;
   logic               wr_acc;
   logic               hit_ctrl;
   logic               hit_point;
   logic               hit_status;
   logic               hit_slice;
   logic               mapped;
   logic               point_bad;

   // Effective type labels
   logic               eff_signed;
   logic [POINT_W-1:0] eff_point;

   // ==========================================================================
   // Datapath lanes
   // Every lane is an identical copy, so no lane can drift from another
   genvar lane;
   generate
      for (lane = 0; lane < samples_per_period_count; lane++) begin : g_lane
         reint_lane u_reint (
            .lane_in  (vec_in[lane*ELEM_W +: ELEM_W]),
            .lane_out (reint_out[lane*ELEM_W +: ELEM_W])
         );
         slice_lane #(
            .SLICE_LO (SLICE_LO),
            .SLICE_W  (SLICE_W)
         ) u_slice (
            .lane_in  (vec_in[lane*ELEM_W +: ELEM_W]),
            .lane_out (slice_out[lane*SLICE_W +: SLICE_W])
         );
      end
   endgenerate

   // ==========================================================================
   // Type labels
   // Labels only; the bits are never touched, so a signed value relabelled
   // unsigned, joined to two low bits and relabelled signed stays a plain
   // bus concatenation downstream
   always_comb begin
      eff_signed = IN_SIGNED;
      eff_point  = IN_POINT_V;
      if (ctrl_q[CTRL_FORCE_TYPE_BIT]) begin
         eff_signed = ctrl_q[CTRL_OUT_SIGNED_BIT];
      end
      if (ctrl_q[CTRL_FORCE_POINT_BIT]) begin
         eff_point = point_q;
      end
   end

   assign reint_signed  = eff_signed;
   assign reint_point   = eff_point;

   // Slice type never follows the input type
   assign slice_signed  = SLICE_SIGNED;
   assign slice_point   = SLICE_POINT;
   assign slice_is_bool = ctrl_q[CTRL_BOOL_OUT_BIT] & ONE_BIT;

   // ==========================================================================
   // APB decode
   // Zero-wait slave: read data is captured in the setup cycle
   assign setup_ph   = psel & ~penable;
   assign access_ph  = psel & penable;
   assign wr_acc     = access_ph & pwrite;
   assign hit_ctrl   = (paddr == CTRL_OFF);
   assign hit_status = (paddr == STATUS_OFF);
   assign hit_point  = (paddr == POINT_OFF);
   assign hit_slice  = (paddr == SLICE_OFF);
   assign mapped     = hit_ctrl | hit_point | hit_status | hit_slice;

   // Out-of-range point is refused before it can mislabel the output
   assign point_bad  = hit_point & pwrite & pstrb[0] & (pwdata > ELEM_W_V);

   assign pready     = 1'b1;
   assign pslverr    = access_ph & (~mapped | point_bad);
   assign prdata     = rdata_q;

   // ==========================================================================
   // Register next-state
   // A new refusal in the same cycle as the clear keeps the flag set
   always_comb begin
      ctrl_d   = ctrl_q;
      point_d  = point_q;
      bad_pt_d = bad_pt_q;
      rdata_d  = rdata_q;

      // Writes take effect in the access cycle only
      if (wr_acc) begin
         if (hit_ctrl && pstrb[0]) begin
            ctrl_d = pwdata[CTRL_W-1:0];
         end
         if (hit_point && pstrb[0] && !point_bad) begin
            point_d = pwdata[POINT_W-1:0];
         end
         if (hit_status && pstrb[2] && pwdata[ST_BAD_POINT_BIT]) begin
            bad_pt_d = 1'b0;
         end
      end
      if (wr_acc && point_bad) begin
         bad_pt_d = 1'b1;
      end

      // Read data prepared during setup, held through access
      if (setup_ph) begin
         rdata_d = '0;
         if (!pwrite) begin
            if (hit_ctrl) begin
               rdata_d[CTRL_W-1:0] = ctrl_q;
            end
            if (hit_point) begin
               rdata_d[POINT_W-1:0] = point_q;
            end
            if (hit_status) begin
               rdata_d[ST_SIGNED_BIT]                   = eff_signed;
               rdata_d[ST_POINT_LSB +: POINT_W]         = eff_point;
               rdata_d[ST_BAD_POINT_BIT]                = bad_pt_q;
            end
            if (hit_slice) begin
               rdata_d[SL_LO_LSB +: 8]  = SLICE_LO_V;
               rdata_d[SL_HI_LSB +: 8]  = SLICE_HI_V;
               rdata_d[SL_W_LSB +: 8]   = SLICE_W_V;
               rdata_d[SL_BOOL_BIT]     = slice_is_bool;
            end
         end
      end
   end

   // ==========================================================================
   // Register storage
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_q   <= CTRL_RST;
         point_q  <= POINT_RST;
         bad_pt_q <= 1'b0;
         rdata_q  <= '0;
      end else begin
         ctrl_q   <= ctrl_d;
         point_q  <= point_d;
         bad_pt_q <= bad_pt_d;
         rdata_q  <= rdata_d;
      end
   end

endmodule

// ==== test/fabric_source.sv ====
// Purpose: upstream fabric model feeding the vector input
// Assumes: upstream presents a new vector once per sample period
// Notes:   registered, so the vector changes only after a clock edge
`timescale 1ns/100ps
module fabric_source
   import reint_slice_pkg::*;
(
   // Clock
   input  wire logic                                       clk,
   // Next vector from the bench
   input  wire logic [samples_per_period_count*ELEM_W-1:0] next_vec,
   // Vector toward the block
   output logic      [samples_per_period_count*ELEM_W-1:0] vec
);
   // Register stage, as the upstream block has
   always_ff @(posedge clk) begin
      vec <= next_vec;
   end
endmodule

// ==== test/vector_reint_slice_assertions.sv ====
// Purpose: port-level checks of the reinterpret and slice block
// Assumes: zero-wait APB slave, labels follow the register writes
// Notes:   bound to every instance of the block
`timescale 1ns/100ps
module vector_reint_slice_checker
   import reint_slice_pkg::*;
#(
   parameter bit IN_SIGNED = 1'b1,
   parameter int IN_POINT  = 2,
   parameter int SLICE_W   = 8
)
(
   // Clock, reset and APB
   input wire logic                                        clk,
   input wire logic                                        resetn,
   input wire logic [ADDR_W-1:0]                           paddr,
   input wire logic                                        psel,
   input wire logic                                        penable,
   input wire logic                                        pwrite,
   input wire logic [DATA_W-1:0]                           pwdata,
   input wire logic [3:0]                                  pstrb,
   input wire logic                                        pready,
   input wire logic                                        pslverr,
   // Datapath
   input wire logic [samples_per_period_count*ELEM_W-1:0]  vec_in,
   input wire logic [samples_per_period_count*ELEM_W-1:0]  reint_out,
   input wire logic                                        reint_signed,
   input wire logic [POINT_W-1:0]                          reint_point,
   input wire logic [samples_per_period_count*SLICE_W-1:0] slice_out,
   input wire logic                                        slice_signed,
   input wire logic [POINT_W-1:0]                          slice_point,
   input wire logic                                        slice_is_bool
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   // Write access cycle
   wire logic acc_wr;
   assign acc_wr = psel & penable & pwrite;
   // ==========================================================================
   // Properties
   property p_reint_copy; reint_out == vec_in; endproperty
   property p_slice_type; !slice_signed && slice_point == 5'h00; endproperty
   property p_bool_one_bit; slice_is_bool |-> (SLICE_W == 1); endproperty
   property p_sign_label;
      acc_wr && paddr == CTRL_OFF && pstrb[0] |=> reint_signed ==
         ($past(pwdata[CTRL_FORCE_TYPE_BIT]) ? $past(pwdata[CTRL_OUT_SIGNED_BIT]) : IN_SIGNED);
   endproperty
   property p_point_kept;
      acc_wr && paddr == CTRL_OFF && pstrb[0] && !pwdata[CTRL_FORCE_POINT_BIT] |=> reint_point == POINT_W'(IN_POINT);
   endproperty
   // A refused point must not leak onto the label
   property p_bad_point;
      acc_wr && paddr == POINT_OFF && pstrb[0] && pwdata > 32'h10 |-> pslverr ##1 $stable(reint_point);
   endproperty
   property p_zero_wait; psel && penable |-> pready; endproperty
   property p_lanes_same;
      vec_in[4*ELEM_W-1 -: ELEM_W] == vec_in[ELEM_W-1:0] |-> slice_out[4*SLICE_W-1 -: SLICE_W] == slice_out[SLICE_W-1:0];
   endproperty
   a_reint_copy: assert property (p_reint_copy) else $error("reint_out differs from vec_in");
   a_slice_type: assert property (p_slice_type) else $error("slice type not unsigned point 0");
   a_bool_one_bit: assert property (p_bool_one_bit) else $error("bool type on wide slice");
   a_sign_label: assert property (p_sign_label) else $error("sign label wrong after write");
   a_point_kept: assert property (p_point_kept) else $error("point not input point");
   a_bad_point: assert property (p_bad_point) else $error("bad point accepted");
   a_zero_wait: assert property (p_zero_wait) else $error("pready low in access");
   a_lanes_same: assert property (p_lanes_same) else $error("lanes map differently");
   // Main scenarios reached
   c_bad: cover property (acc_wr && paddr == POINT_OFF && pslverr);
   c_bool: cover property (slice_is_bool);
   c_force: cover property (acc_wr && paddr == CTRL_OFF && pwdata[CTRL_FORCE_POINT_BIT]);
endmodule
bind vector_reint_slice vector_reint_slice_checker #(.IN_SIGNED(IN_SIGNED), .IN_POINT(IN_POINT), .SLICE_W(SLICE_W))
   checker_inst (.clk(clk), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
   .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr), .vec_in(vec_in), .reint_out(reint_out),
   .reint_signed(reint_signed), .reint_point(reint_point), .slice_out(slice_out), .slice_signed(slice_signed),
   .slice_point(slice_point), .slice_is_bool(slice_is_bool));

// ==== test/test_vector_reint_slice.sv ====
// Purpose: self-checking bench for the reinterpret and slice block
// Assumes: two instances, wide slice from the binary point and one-bit top slice
// Notes:   both instances share the APB bus; only the first answers reads
`timescale 1ns/100ps
module test_vector_reint_slice
   import reint_slice_pkg::*;
;
   logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, rs1, rs2, rb1, rb2;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0]       pwdata = '0, prdata, rd;
   logic [3:0]        pstrb = '0;
   logic [63:0]       next_vec = '0, vec_in, ro1, ro2, v;
   logic [31:0]       so1;
   logic [3:0]        so2;
   logic [4:0]        rp1, rp2, sp1, sp2;
   logic              err, ss1, ss2;
   int                mismatches = 0, tests_run = 0;
   // ==========================================================================
   // Clock, partner and devices
   always #5 clk = ~clk;
   fabric_source fabric_source_inst (.clk(clk), .next_vec(next_vec), .vec(vec_in));
   // Slice low end = point 2 + offset 1
   vector_reint_slice #(.IN_SIGNED(1'b1), .IN_POINT(2), .SLICE_W(8), .RANGE_MODE(range_lower_width),
      .BOTTOM_REF(point_reference), .BOTTOM_OFFSET(1)) vector_reint_slice_inst (.clk(clk), .resetn(resetn),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .vec_in(vec_in), .reint_out(ro1), .reint_signed(rs1),
      .reint_point(rp1), .slice_out(so1), .slice_signed(ss1), .slice_point(sp1), .slice_is_bool(rb1));
   // Unsigned input, one-bit slice at the top bit
   vector_reint_slice #(.IN_SIGNED(1'b0), .IN_POINT(0), .SLICE_W(1), .RANGE_MODE(range_upper_width),
      .TOP_REF(top_bit_reference), .TOP_OFFSET(0)) vector_reint_slice_inst2 (.clk(clk), .resetn(resetn),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(), .pready(), .pslverr(), .vec_in(vec_in), .reint_out(ro2), .reint_signed(rs2),
      .reint_point(rp2), .slice_out(so2), .slice_signed(ss2), .slice_point(sp2), .slice_is_bool(rb2));
   // ==========================================================================
   // Shared tasks
   task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Setup, then access held until pready is sampled high
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      @(posedge clk);
      paddr <= a; pwrite <= w; pwdata <= d; pstrb <= 4'hf; psel <= 1'b1; penable <= 1'b0;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0; penable <= 1'b0; pstrb <= 4'h0;
   endtask
   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // ==========================================================================
   // Scenarios
   task automatic t_reset();
      apb(CTRL_OFF, 0, 0, rd, err); check("ctrl reset", rd, 0);
      apb(POINT_OFF, 0, 0, rd, err); check("point reset", rd, 0);
      check("signed label", {rs1, rs2}, 2'b10);
      check("point label", {rp1, rp2}, {5'd2, 5'd0});
      check("slice type", {ss1, sp1, ss2, sp2}, 12'h000);
      apb(SLICE_OFF, 0, 0, rd, err); check("slice desc", rd, 32'h00080a03);
      $display("t_reset done");
   endtask
   task automatic t_data();
      logic [63:0] tbl [3] = '{64'h8001_7ffe_ffff_0000, 64'h1234_5678_9abc_def0, 64'ha5a5_a5a5_a5a5_a5a5};
      foreach (tbl[k]) begin
         @(posedge clk); next_vec <= tbl[k];
         repeat (2) @(posedge clk);
         v = tbl[k];
         check("reint 1", ro1, v);
         check("reint 2", ro2, v);
         for (int i = 0; i < 4; i++) begin
            check("slice wide", so1[8*i +: 8], v[16*i+3 +: 8]);
            check("slice top", so2[i], v[16*i+15]);
         end
      end
      $display("t_data done");
   endtask
   task automatic t_labels();
      logic [3:0] c [4] = '{4'h1, 4'h3, 4'h6, 4'h5};
      apb(POINT_OFF, 1, 32'h10, rd, err); check("point 16 ok", err, 0);
      foreach (c[k]) begin
         apb(CTRL_OFF, 1, {28'h0, c[k]}, rd, err);
         // Labels change at the write edge itself; look half a cycle later
         @(negedge clk);
         check("signed 1", rs1, c[k][0] ? c[k][1] : 1'b1);
         check("point 2", rp2, c[k][2] ? 5'd16 : 5'd0);
         check("signed 2", rs2, c[k][0] ? c[k][1] : 1'b0);
         check("point 1", rp1, c[k][2] ? 5'd16 : 5'd2);
         check("data kept", ro1, v);
      end
      apb(CTRL_OFF, 1, 0, rd, err);
      $display("t_labels done");
   endtask
   task automatic t_refuse();
      apb(POINT_OFF, 1, 32'h11, rd, err); check("bad point err", err, 1);
      apb(POINT_OFF, 0, 0, rd, err); check("point kept", rd, 32'h10);
      apb(STATUS_OFF, 0, 0, rd, err); check("status bad", rd, 32'h00010201);
      apb(STATUS_OFF, 1, 32'h00010000, rd, err);
      apb(STATUS_OFF, 0, 0, rd, err); check("status clear", rd, 32'h00000201);
      apb(12'h010, 0, 0, rd, err); check("unmapped", {err, rd}, {1'b1, 32'h0});
      $display("t_refuse done");
   endtask
   task automatic t_bool();
      apb(CTRL_OFF, 1, 32'h8, rd, err);
      @(negedge clk);
      check("bool flags", {rb1, rb2}, 2'b01);
      apb(SLICE_OFF, 0, 0, rd, err); check("slice desc", rd, 32'h00080a03);
      apb(CTRL_OFF, 1, 0, rd, err);
      @(negedge clk);
      check("bool off", rb2, 0);
      $display("t_bool done");
   endtask
   // ==========================================================================
   // Main sequence and watchdog
   initial begin
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      t_reset();
      t_data();
      t_labels();
      t_refuse();
      t_bool();
      final_report();
   end
   // Whole run needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clk);
      mismatches++;
      final_report();
   end
endmodule
